// file: rtl/clk_divider.sv
// Run-gated clock divider producing an output clock level and a rise enable pulse
`timescale 1ns/100ps
module clk_divider #(
  parameter int HALF = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  div_if.gen d
);
  logic [7:0] cnt;
  logic [7:0] next_cnt;
  logic level;
  logic next_level;

  // Toggle every HALF cycles; held low when not running
  always_comb
  begin
    next_cnt = cnt;
    next_level = level;
    if (!d.run)
    begin
      next_cnt = tx_ovh_pkg::DIV_RESET;
      next_level = 1'b0;
    end
    else if (cnt == 8'(HALF - 1))
    begin
      next_cnt = tx_ovh_pkg::DIV_RESET;
      next_level = !level;
    end
    else
    begin
      next_cnt = cnt + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt <= tx_ovh_pkg::DIV_RESET;
      level <= 1'b0;
    end
    else
    begin
      cnt <= next_cnt;
      level <= next_level;
    end
  end

  assign d.level = level;
  // Rise pulse stands the cycle before the output goes high, so captures land with the rise
  assign d.rise = d.run && !level && (cnt == 8'(HALF - 1));
endmodule

// file: rtl/div_if.sv
// Carrier between the main block and its clock dividers
`timescale 1ns/100ps
interface div_if;
  logic run;
  logic level;
  logic rise;
  modport gen (input run, output level, output rise);
  modport use_side (output run, input level, input rise);
endinterface

// file: rtl/tx_ovh_pkg.sv
// Constants and types shared by the transmit overhead / payload pin block
package tx_ovh_pkg;
  typedef enum logic [1:0] {MODE_CLEAR, MODE_ATM_PLCP, MODE_ATM_DIRECT, MODE_HDLC} mode_t;

  localparam int CLK_PERIOD_NS = 5;
  localparam int POH_CLK_PERIOD_NS = 160;
  localparam int HDLC_CLK_PERIOD_NS = 80;
  localparam int POH_HALF_CYCLES = POH_CLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam int HDLC_HALF_CYCLES = HDLC_CLK_PERIOD_NS / (2 * CLK_PERIOD_NS);

  // Payload bits plus one overhead bit per block
  localparam logic [6:0] OH_SPACING = 7'h55;
  localparam logic [6:0] OH_SLOT = OH_SPACING - 7'h01;
  localparam logic [6:0] OH_WARN_SLOT = OH_SPACING - 7'h02;
  localparam logic [11:0] PLCP_LAST_NIBBLE = 12'h4f7;
  localparam logic [2:0] POH_MSB_INDEX = 3'h0;
  localparam logic [7:0] DIV_RESET = 8'h00;
endpackage

// file: rtl/tx_ovh_port.sv
// Transmit overhead, payload and HDLC bit 6 pins multiplexed by operating mode
`timescale 1ns/100ps
module tx_ovh_port (
  input wire logic clk,
  input wire logic rst_n,
  input wire tx_ovh_pkg::mode_t mode,
  input wire logic tx_bit_clock,
  input wire logic serial_payload_in,
  input wire logic poh_insert_enable,
  input wire logic poh_serial_in,
  output logic poh_insert_clock,
  output logic poh_msb_marker,
  input wire logic shared_pin_in,
  output logic shared_pin_out,
  output logic shared_pin_oe_n,
  input wire logic [6:0] hdlc_byte_in_others,
  input wire logic hdlc_send_enable,
  output logic hdlc_input_clock,
  output logic payload_bit,
  output logic payload_valid,
  output logic poh_bit,
  output logic poh_valid,
  output logic [7:0] hdlc_byte,
  output logic hdlc_byte_valid,
  output logic hdlc_frame_start,
  output logic hdlc_frame_end
);
  div_if poh_div ();
  div_if hdlc_div ();

  logic [13:0] sync1;
  logic [13:0] sync2;
  logic bc_prev;
  logic bc_rise;
  logic is_clear;
  logic is_plcp;
  logic is_hdlc;

  // Every pin input except mode passes two flops before any logic sees it
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1 <= 14'h0000;
      sync2 <= 14'h0000;
      bc_prev <= 1'b0;
    end
    else
    begin
      sync1 <= {tx_bit_clock, serial_payload_in, poh_insert_enable, poh_serial_in,
                shared_pin_in, hdlc_byte_in_others, hdlc_send_enable, 1'b0};
      sync2 <= sync1;
      bc_prev <= sync2[13];
    end
  end

  assign bc_rise = sync2[13] && !bc_prev;
  assign is_clear = (mode == tx_ovh_pkg::MODE_CLEAR);
  assign is_plcp = (mode == tx_ovh_pkg::MODE_ATM_PLCP);
  assign is_hdlc = (mode == tx_ovh_pkg::MODE_HDLC);

  // Overhead insertion clock only runs in ATM/PLCP mode, never gated by the enable
  assign poh_div.run = is_plcp;
  assign hdlc_div.run = is_hdlc;

  clk_divider #(.HALF(tx_ovh_pkg::POH_HALF_CYCLES)) u_poh_div (
    .clk(clk),
    .rst_n(rst_n),
    .d(poh_div)
  );

  clk_divider #(.HALF(tx_ovh_pkg::HDLC_HALF_CYCLES)) u_hdlc_div (
    .clk(clk),
    .rst_n(rst_n),
    .d(hdlc_div)
  );

  // Clear-channel bit slots and PLCP nibble pacing, both timed by the bit clock
  logic [6:0] bit_cnt;
  logic [6:0] next_bit_cnt;
  logic warn;
  logic next_warn;
  logic pay_bit;
  logic next_pay_bit;
  logic pay_valid;
  logic next_pay_valid;
  logic [1:0] nib_phase;
  logic [1:0] next_nib_phase;
  logic [11:0] nib_cnt;
  logic [11:0] next_nib_cnt;

  always_comb
  begin
    next_bit_cnt = bit_cnt;
    next_warn = warn;
    next_pay_bit = pay_bit;
    next_pay_valid = 1'b0;
    next_nib_phase = nib_phase;
    next_nib_cnt = nib_cnt;
    if (!is_clear)
    begin
      next_bit_cnt = 7'h00;
      next_warn = 1'b0;
    end
    else if (bc_rise)
    begin
      next_bit_cnt = (bit_cnt == tx_ovh_pkg::OH_SLOT) ? 7'h00 : bit_cnt + 7'h01;
      // Warn one bit ahead; drops at the overhead edge itself
      next_warn = (bit_cnt == tx_ovh_pkg::OH_WARN_SLOT);
      if (bit_cnt != tx_ovh_pkg::OH_SLOT)
      begin
        next_pay_bit = sync2[12];
        next_pay_valid = 1'b1;
      end
    end
    if (!is_plcp)
    begin
      next_nib_phase = 2'h0;
      next_nib_cnt = 12'h000;
    end
    else if (bc_rise)
    begin
      next_nib_phase = nib_phase + 2'h1;
      if (nib_phase == 2'h3)
      begin
        next_nib_cnt = (nib_cnt == tx_ovh_pkg::PLCP_LAST_NIBBLE) ? 12'h000 : nib_cnt + 12'h001;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bit_cnt <= 7'h00;
      warn <= 1'b0;
      pay_bit <= 1'b0;
      pay_valid <= 1'b0;
      nib_phase <= 2'h0;
      nib_cnt <= 12'h000;
    end
    else
    begin
      bit_cnt <= next_bit_cnt;
      warn <= next_warn;
      pay_bit <= next_pay_bit;
      pay_valid <= next_pay_valid;
      nib_phase <= next_nib_phase;
      nib_cnt <= next_nib_cnt;
    end
  end

  // Shared pin: mode alone picks function and direction; direct ATM drives it low
  always_comb
  begin
    shared_pin_oe_n = is_hdlc;
    if (is_clear)
    begin
      shared_pin_out = warn;
    end
    else if (is_plcp)
    begin
      shared_pin_out = (nib_cnt == tx_ovh_pkg::PLCP_LAST_NIBBLE);
    end
    else
    begin
      shared_pin_out = 1'b0;
    end
  end

  // Path overhead serial capture on the generated clock
  logic [2:0] poh_idx;
  logic [2:0] next_poh_idx;
  logic poh_b;
  logic next_poh_b;
  logic poh_v;
  logic next_poh_v;

  always_comb
  begin
    next_poh_idx = poh_idx;
    next_poh_b = poh_b;
    next_poh_v = 1'b0;
    if (!is_plcp || !sync2[11])
    begin
      next_poh_idx = tx_ovh_pkg::POH_MSB_INDEX;
    end
    else if (poh_div.rise)
    begin
      next_poh_b = sync2[10];
      next_poh_v = 1'b1;
      next_poh_idx = poh_idx + 3'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      poh_idx <= 3'h0;
      poh_b <= 1'b0;
      poh_v <= 1'b0;
    end
    else
    begin
      poh_idx <= next_poh_idx;
      poh_b <= next_poh_b;
      poh_v <= next_poh_v;
    end
  end

  // HDLC byte capture; bit 6 comes from the shared pin
  logic [7:0] h_byte;
  logic [7:0] next_h_byte;
  logic h_valid;
  logic next_h_valid;
  logic in_frame;
  logic next_in_frame;
  logic h_start;
  logic next_h_start;
  logic h_end;
  logic next_h_end;

  always_comb
  begin
    next_h_byte = h_byte;
    next_h_valid = 1'b0;
    next_in_frame = in_frame;
    next_h_start = 1'b0;
    next_h_end = 1'b0;
    if (!is_hdlc)
    begin
      next_in_frame = 1'b0;
    end
    else if (hdlc_div.rise)
    begin
      if (sync2[1])
      begin
        next_h_byte = {sync2[8], sync2[9], sync2[7:2]};
        next_h_valid = 1'b1;
        next_h_start = !in_frame;
        next_in_frame = 1'b1;
      end
      else if (in_frame)
      begin
        next_h_end = 1'b1;
        next_in_frame = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      h_byte <= 8'h00;
      h_valid <= 1'b0;
      in_frame <= 1'b0;
      h_start <= 1'b0;
      h_end <= 1'b0;
    end
    else
    begin
      h_byte <= next_h_byte;
      h_valid <= next_h_valid;
      in_frame <= next_in_frame;
      h_start <= next_h_start;
      h_end <= next_h_end;
    end
  end

  // Outputs
  assign poh_insert_clock = poh_div.level;
  assign poh_msb_marker = is_plcp && (poh_idx == tx_ovh_pkg::POH_MSB_INDEX);
  assign hdlc_input_clock = hdlc_div.level;
  assign payload_bit = pay_bit;
  assign payload_valid = pay_valid;
  assign poh_bit = poh_b;
  assign poh_valid = poh_v;
  assign hdlc_byte = h_byte;
  assign hdlc_byte_valid = h_valid;
  assign hdlc_frame_start = h_start;
  assign hdlc_frame_end = h_end;
endmodule

// file: tb/tb.sv
// Self-checking bench for the transmit overhead pin block
`timescale 1ns/100ps
module tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  tx_ovh_pkg::mode_t mode = tx_ovh_pkg::MODE_CLEAR;
  logic poh_insert_enable = 1'b0;
  logic poh_serial_in = 1'b0;
  logic shared_pin_in = 1'b0;
  logic [6:0] hdlc_byte_in_others = 7'h00;
  logic hdlc_send_enable = 1'b0;
  logic tx_bit_clock, serial_payload_in, poh_insert_clock, poh_msb_marker, shared_pin_out;
  logic shared_pin_oe_n, hdlc_input_clock, payload_bit, payload_valid, poh_bit, poh_valid;
  logic [7:0] hdlc_byte;
  logic hdlc_byte_valid, hdlc_frame_start, hdlc_frame_end;
  int err_count = 0;
  int checked = 0;
  always #2.5 clk = ~clk;
  tx_ovh_port dut (.clk, .rst_n, .mode, .tx_bit_clock, .serial_payload_in, .poh_insert_enable,
    .poh_serial_in, .poh_insert_clock, .poh_msb_marker, .shared_pin_in, .shared_pin_out,
    .shared_pin_oe_n, .hdlc_byte_in_others, .hdlc_send_enable, .hdlc_input_clock, .payload_bit,
    .payload_valid, .poh_bit, .poh_valid, .hdlc_byte, .hdlc_byte_valid, .hdlc_frame_start,
    .hdlc_frame_end);
  term_equip_model p (.rst_n, .warning(shared_pin_out), .tx_bit_clock, .serial_payload_in);
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD %s exp %h seen %h", name, exp, seen);
    end
  endtask
  task automatic complete_run();
    if (err_count == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Mode changes only under reset; release just after a bit clock fall
  task automatic set_mode(input tx_ovh_pkg::mode_t m);
    rst_n = 1'b0;
    mode = m;
    repeat (2) @(posedge clk);
    @(negedge tx_bit_clock);
    @(posedge clk);
    #1 rst_n = 1'b1;
  endtask
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  // Two overhead blocks; dropped slots keep the payload sequence whole
  task automatic test_clear();
    logic [15:0] j;
    logic [15:0] w;
    j = 16'h0000;
    w = 16'h0000;
    set_mode(tx_ovh_pkg::MODE_CLEAR);
    repeat (5500)
    begin
      tick();
      w = w + shared_pin_out;
      if (payload_valid === 1'b1)
      begin
        check("payload_bit", payload_bit, j[0] ^ j[2]);
        j++;
      end
    end
    check("payload_count", j, 16'h00aa);
    check("warning_cycles", w, 16'h0040);
  endtask
  // Overhead port with enable high, then low while its clock keeps running
  task automatic test_poh();
    logic [15:0] nv;
    logic [15:0] nr;
    logic prev;
    set_mode(tx_ovh_pkg::MODE_ATM_PLCP);
    for (int e = 1; e >= 0; e--)
    begin
      poh_insert_enable = e[0];
      poh_serial_in = e[0];
      repeat (8) tick();
      nv = 16'h0000;
      nr = 16'h0000;
      prev = poh_insert_clock;
      repeat (640)
      begin
        tick();
        nv = nv + poh_valid;
        nr = nr + (poh_insert_clock & ~prev);
        prev = poh_insert_clock;
        if (poh_valid === 1'b1)
          check("poh_bit", poh_bit, 1'b1);
      end
      check("poh_captures", nv, e ? 16'h0014 : 16'h0000);
      check("poh_clock_rises", nr, 16'h0014);
      check("boundary_early", shared_pin_out, 1'b0);
      check("msb_marker", poh_msb_marker, e ? 1'b0 : 1'b1);
    end
  endtask
  // Bytes with bit 6 on the shared pin, then the frame closes
  task automatic test_hdlc();
    logic [7:0] v [4] = '{8'h40, 8'hbf, 8'h15, 8'hea};
    logic [15:0] fe;
    logic [15:0] bv;
    int n;
    set_mode(tx_ovh_pkg::MODE_HDLC);
    check("pin_oe_n", shared_pin_oe_n, 1'b1);
    foreach (v[i])
    begin
      @(negedge hdlc_input_clock);
      #1;
      {hdlc_byte_in_others[6], shared_pin_in, hdlc_byte_in_others[5:0]} = v[i];
      hdlc_send_enable = 1'b1;
      n = 0;
      while (hdlc_byte_valid !== 1'b1 && n < 20)
      begin
        tick();
        n++;
      end
      check("hdlc_byte", hdlc_byte, v[i]);
      check("frame_start", hdlc_frame_start, i == 0);
    end
    @(negedge hdlc_input_clock);
    #1;
    hdlc_send_enable = 1'b0;
    fe = 16'h0000;
    bv = 16'h0000;
    repeat (40)
    begin
      tick();
      fe = fe + hdlc_frame_end;
      bv = bv + hdlc_byte_valid;
    end
    check("frame_end", fe, 16'h0001);
    check("late_bytes", bv, 16'h0000);
  endtask
  // Direct ATM mode: no boundary pulse, and neither generated clock runs
  task automatic test_direct();
    set_mode(tx_ovh_pkg::MODE_ATM_DIRECT);
    repeat (200) tick();
    check("direct_boundary", shared_pin_out, 1'b0);
    check("direct_poh_clock", poh_insert_clock, 1'b0);
    check("direct_msb_marker", poh_msb_marker, 1'b0);
    check("direct_oe_n", shared_pin_oe_n, 1'b0);
    check("direct_hdlc_clock", hdlc_input_clock, 1'b0);
  endtask
  // Watchdog well beyond the expected run length
  initial
  begin
    #200000;
    err_count++;
    complete_run();
  end
  initial
  begin
    test_clear();
    test_poh();
    test_hdlc();
    test_direct();
    complete_run();
  end
endmodule
bind tx_ovh_port tx_ovh_assertions chk (.clk, .rst_n, .mode, .hdlc_send_enable,
  .poh_insert_clock, .shared_pin_out, .shared_pin_oe_n, .hdlc_input_clock, .poh_valid,
  .hdlc_byte_valid);

// file: tb/term_equip_model.sv
// Terminal equipment model feeding the clear-channel payload stream
`timescale 1ns/100ps
module term_equip_model (
  input wire logic rst_n,
  input wire logic warning,
  output logic tx_bit_clock,
  output logic serial_payload_in
);
  logic [15:0] k;
  logic [15:0] nk;
  assign nk = k + 16'h0001;
  // Free bit clock, phase unrelated to the block clock
  initial
  begin
    tx_bit_clock = 1'b0;
    #37;
    forever #80 tx_bit_clock = ~tx_bit_clock;
  end
  // New bit on each fall; junk is the inverse so a wrong capture shows
  always @(negedge tx_bit_clock or negedge rst_n)
    if (!rst_n)
    begin
      k <= 16'h0000;
      serial_payload_in <= 1'b0;
    end
    else if (warning)
      serial_payload_in <= ~(nk[0] ^ nk[2]);
    else
    begin
      k <= nk;
      serial_payload_in <= nk[0] ^ nk[2];
    end
endmodule

// file: tb/tx_ovh_assertions.sv
// Assertion checker for the transmit overhead pin block
`timescale 1ns/100ps
module tx_ovh_assertions (
  input wire logic clk,
  input wire logic rst_n,
  input wire tx_ovh_pkg::mode_t mode,
  input wire logic hdlc_send_enable,
  input wire logic poh_insert_clock,
  input wire logic shared_pin_out,
  input wire logic shared_pin_oe_n,
  input wire logic hdlc_input_clock,
  input wire logic poh_valid,
  input wire logic hdlc_byte_valid
);
  logic [7:0] hi_len;
  logic [7:0] next_hi_len;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // Pulse length counter; a clear-mode warning lasts 32 cycles and a PLCP boundary pulse 128, so 8 bits cannot wrap
  always_comb next_hi_len = shared_pin_out ? hi_len + 8'h01 : 8'h00;
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      hi_len <= 8'h00;
    else
      hi_len <= next_hi_len;
  a_poh_clk_idle: assert property (
    mode != tx_ovh_pkg::MODE_ATM_PLCP |-> !poh_insert_clock) else $error("poh clock active");
  a_poh_clk_runs: assert property (
    $rose(poh_insert_clock) |-> ##16 !poh_insert_clock ##16 poh_insert_clock)
    else $error("poh clock period wrong");
  a_hdlc_clk_runs: assert property (
    $rose(hdlc_input_clock) |-> ##8 !hdlc_input_clock ##8 hdlc_input_clock)
    else $error("hdlc clock period wrong");
  a_hdlc_clk_idle: assert property (
    mode != tx_ovh_pkg::MODE_HDLC |-> !hdlc_input_clock) else $error("hdlc clock active");
  a_pin_dir_mode: assert property (
    shared_pin_oe_n == (mode == tx_ovh_pkg::MODE_HDLC)) else $error("pin direction wrong");
  a_direct_low: assert property (
    mode == tx_ovh_pkg::MODE_ATM_DIRECT |-> !shared_pin_out) else $error("boundary active");
  a_warn_one_bit: assert property (
    mode == tx_ovh_pkg::MODE_CLEAR && $fell(shared_pin_out) |-> hi_len == 8'h20)
    else $error("warning length wrong");
  a_hdlc_byte_take: assert property (
    mode == tx_ovh_pkg::MODE_HDLC && $rose(hdlc_input_clock) && hdlc_send_enable
    && $past(hdlc_send_enable) && $past(hdlc_send_enable, 3) |-> hdlc_byte_valid)
    else $error("hdlc byte missed");
  a_poh_on_rise: assert property (
    poh_valid |-> poh_insert_clock && !$past(poh_insert_clock))
    else $error("poh capture off clock rise");
  c_warn: cover property ($fell(shared_pin_out));
  c_poh: cover property (poh_valid);
  c_hdlc: cover property (hdlc_byte_valid);
endmodule
